/* core/ldem_err_counter.sv */
// Saturating per-lane error counter with terminal-count flag
`timescale 1ns/1ns
`include "ldem_regs.svh"

module ldem_err_counter #(
  parameter int W = `LDEM_CNT_WIDTH
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic clr_i,
  input wire logic event_i,
  output logic [W-1:0] count_o,
  output logic full_o
);

  localparam logic [W-1:0] TERMINAL = {W{1'b1}};

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  logic full_q;
  logic full_d;

  always_comb begin
    count_d = count_q;
    if (clr_i) begin
      count_d = '0;
    end else if (event_i && (count_q != TERMINAL)) begin
      // Holds at terminal so the flag and the count never disagree
      count_d = count_q + {{(W-1){1'b0}}, 1'b1};
    end
    full_d = (count_d == TERMINAL);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      count_q <= '0;
      full_q <= 1'b0;
    end else begin
      count_q <= count_d;
      full_q <= full_d;
    end
  end

  assign count_o = count_q;
  assign full_o = full_q;

endmodule : ldem_err_counter

/* core/ldem_monitor.sv */
// Lane decode error monitor: per-lane error counters and read-only status registers
`timescale 1ns/1ns
`include "ldem_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module ldem_monitor #(
  parameter int LANES = `LDEM_LANES,
  parameter int CNT_W = `LDEM_CNT_WIDTH
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [LANES-1:0] lane_active_i,
  input ldem_pkg::ldem_lane_err_t [LANES-1:0] lane_err_i,
  input ldem_pkg::ldem_rd_req_t rd_req_i,
  output ldem_pkg::ldem_rd_rsp_t rd_rsp_o,
  output logic count_full_any_o
);

  localparam int NTYPES = `LDEM_ERR_TYPES;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Status byte layout: reserved high nibble, enable, three terminal flags
  function automatic logic [7:0] status_byte(input logic active, input logic [2:0] flags);
    logic [7:0] b;
    b = `LDEM_REG_RESET;
    b[`LDEM_STAT_ACTIVE_BIT] = active;
    b[`LDEM_STAT_FLAGS_MSB:`LDEM_STAT_FLAGS_LSB] = flags;
    return b;
  endfunction : status_byte

  // Counters are wider than the register only if CNT_W is raised; show the low byte
  function automatic logic [7:0] count_byte(input logic [CNT_W-1:0] c);
    logic [7:0] b;
    b = `LDEM_REG_RESET;
    for (int k = 0; k < CNT_W && k < 8; k++) begin
      b[k] = c[k];
    end
    return b;
  endfunction : count_byte

  ////////////////////////////////////////////////////////////////////////////////
  // Lane enable capture

  logic [LANES-1:0] active_q;
  logic [LANES-1:0] active_d;

  always_comb begin
    active_d = lane_active_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      active_q <= '0;
    end else begin
      active_q <= active_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Error counters, one per lane and error type

  logic [CNT_W-1:0] cnt [LANES][NTYPES];
  logic [NTYPES-1:0] full [LANES];

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [NTYPES-1:0] ev;
    logic [NTYPES-1:0] full_bits;
    // Struct packs straight into the flag order, so index t is also the flag bit
    assign ev = lane_err_i[l];
    for (genvar t = 0; t < NTYPES; t++) begin : g_type
      // A lane in soft reset has its counters cleared and ignores its decoder
      ldem_err_counter #(
        .W(CNT_W)
      ) u_cnt (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .clr_i(!active_q[l]),
        .event_i(ev[t]),
        .count_o(cnt[l][t]),
        .full_o(full_bits[t])
      );
    end
    assign full[l] = full_bits;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Summary flag

  logic any_full_q;
  logic any_full_d;

  always_comb begin
    any_full_d = 1'b0;
    for (int l = 0; l < LANES; l++) begin
      any_full_d = any_full_d | (|full[l]);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      any_full_q <= 1'b0;
    end else begin
      any_full_q <= any_full_d;
    end
  end

  assign count_full_any_o = any_full_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Read port

  ldem_pkg::ldem_rd_rsp_t rsp_q;
  ldem_pkg::ldem_rd_rsp_t rsp_d;

  // Data holds between reads so a slow shifter can take its time
  always_comb begin
    rsp_d.valid = rd_req_i.en;
    rsp_d.data = rsp_q.data;
    if (rd_req_i.en) begin
      case (rd_req_i.addr)
        `LDEM_OFS_LANE5_ERROR_STATUS: begin
          rsp_d.data = status_byte(active_q[5], full[5]);
        end
        `LDEM_OFS_LANE6_ERROR_STATUS: begin
          rsp_d.data = status_byte(active_q[6], full[6]);
        end
        `LDEM_OFS_LANE7_ERROR_STATUS: begin
          rsp_d.data = status_byte(active_q[7], full[7]);
        end
        `LDEM_OFS_LANE0_DISPARITY_ERRORS: begin
          rsp_d.data = count_byte(cnt[0][0]);
        end
        `LDEM_OFS_LANE1_DISPARITY_ERRORS: begin
          rsp_d.data = count_byte(cnt[1][0]);
        end
        `LDEM_OFS_LANE2_DISPARITY_ERRORS: begin
          rsp_d.data = count_byte(cnt[2][0]);
        end
        `LDEM_OFS_LANE3_DISPARITY_ERRORS: begin
          rsp_d.data = count_byte(cnt[3][0]);
        end
        `LDEM_OFS_LANE4_DISPARITY_ERRORS: begin
          rsp_d.data = count_byte(cnt[4][0]);
        end
        `LDEM_OFS_LANE5_DISPARITY_ERRORS: begin
          rsp_d.data = count_byte(cnt[5][0]);
        end
        default: begin
          // Unmapped addresses answer zero
          rsp_d.data = `LDEM_REG_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rsp_q.valid <= 1'b0;
      rsp_q.data <= `LDEM_REG_RESET;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign rd_rsp_o = rsp_q;

endmodule : ldem_monitor

/* inc/ldem_pkg.sv */
// Types shared by the lane decode error monitor
package ldem_pkg;

  // Bit order matches the terminal-count field: [2] control char, [1] code group, [0] disparity
  typedef struct packed {
    logic unexpected_control_char;
    logic invalid_code_group;
    logic disparity_violation;
  } ldem_lane_err_t;

  typedef struct packed {
    logic en;
    logic [11:0] addr;
  } ldem_rd_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ldem_rd_rsp_t;

endpackage : ldem_pkg

/* inc/ldem_regs.svh */
// Register offsets, field positions and reset values of the lane decode error monitor
`ifndef LDEM_REGS_SVH
`define LDEM_REGS_SVH

// Width of the configuration port address
`define LDEM_ADDR_W 12

// Lane status registers, lanes 5 to 7
`define LDEM_OFS_LANE5_ERROR_STATUS 12'h495
`define LDEM_OFS_LANE6_ERROR_STATUS 12'h496
`define LDEM_OFS_LANE7_ERROR_STATUS 12'h497

// Disparity error counters, lanes 0 to 5
`define LDEM_OFS_LANE0_DISPARITY_ERRORS 12'h498
`define LDEM_OFS_LANE1_DISPARITY_ERRORS 12'h499
`define LDEM_OFS_LANE2_DISPARITY_ERRORS 12'h49a
`define LDEM_OFS_LANE3_DISPARITY_ERRORS 12'h49b
`define LDEM_OFS_LANE4_DISPARITY_ERRORS 12'h49c
`define LDEM_OFS_LANE5_DISPARITY_ERRORS 12'h49d

// Status register fields
`define LDEM_STAT_ACTIVE_BIT 3
`define LDEM_STAT_FLAGS_MSB 2
`define LDEM_STAT_FLAGS_LSB 0

// Counter and register geometry
`define LDEM_CNT_WIDTH 8
`define LDEM_REG_RESET 8'h00
`define LDEM_LANES 8
`define LDEM_ERR_TYPES 3

`endif

/* tb/lane_decode_error_monitor_test.sv */
// Self-checking bench for the lane decode error monitor
`timescale 1ns/1ns
module lane_decode_error_monitor_test;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] act = 8'h00;
  logic go = 1'b0;
  logic [4:0] sel = 5'h00;
  ldem_pkg::ldem_lane_err_t [7:0] err;
  ldem_pkg::ldem_rd_req_t rq = '0;
  ldem_pkg::ldem_rd_rsp_t rsp;
  logic full_any;
  logic [7:0] expq[$];
  int fail_count = 0;
  int compares = 0;
  int seed = 32'hf62e;
  int n;
  always #50 clk_sys_i = ~clk_sys_i;
  ldem_err_src ldem_err_src_inst (.clk_sys_i(clk_sys_i), .go_i(go), .sel_i(sel), .err_o(err));
  ldem_monitor ldem_monitor_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .lane_active_i(act),
    .lane_err_i(err), .rd_req_i(rq), .rd_rsp_o(rsp), .count_full_any_o(full_any));
  task tally_and_finish;
    if (expq.size() != 0) begin
      fail_count++;
      $display("unexpected at %0t: %0d reads never answered", $time, expq.size());
    end
    $display("fail_count=%0d compares=%0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk_sys_i) #1 rq = {1'b1, a};
    expq.push_back(e);
    @(posedge clk_sys_i) #1 rq.en = 1'b0;
  endtask : rd
  task chk_full(input logic e);
    compares++;
    if (full_any !== e) begin
      fail_count++;
      $display("unexpected at %0t: summary flag %b", $time, full_any);
    end
  endtask : chk_full
  // One error pulse per cycle, k cycles long
  task hit(input int l, input int t, input int k);
    repeat (k) @(posedge clk_sys_i) #1 {go, sel} = {1'b1, 5'(3 * l + t)};
    @(posedge clk_sys_i) #1 go = 1'b0;
  endtask : hit
  always @(negedge clk_sys_i) begin
    if (rsp.valid === 1'b1) begin
      compares++;
      if (expq.size() == 0) begin
        fail_count++;
        $display("unexpected at %0t: read answer with no read pending", $time);
      end else if (rsp.data !== expq.pop_front()) begin
        fail_count++;
        $display("unexpected at %0t: read data %h", $time, rsp.data);
      end
    end
  end
  initial begin
    #1000000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clk_sys_i);
    #1 nrst_i = 1'b1;
    for (int a = 12'h494; a <= 12'h49e; a++) rd(12'(a), 8'h00);
    @(posedge clk_sys_i) #1 act = 8'hff;
    for (int l = 5; l < 8; l++) rd(12'h490 + 12'(l), 8'h08);
    for (int l = 0; l < 6; l++) begin
      n = $random(seed) & 8'h7f;
      hit(l, 0, n);
      rd(12'h498 + 12'(l), 8'(n));
    end
    // Errors while held in soft reset must not count
    @(posedge clk_sys_i) #1 act = 8'h00;
    hit(0, 0, 5);
    rd(12'h495, 8'h00);
    rd(12'h498, 8'h00);
    @(posedge clk_sys_i) #1 act = 8'hff;
    for (int t = 0; t < 3; t++) begin
      hit(5 + t, t, 254);
      rd(12'h495 + 12'(t), 8'h08);
      hit(5 + t, t, 2);
      rd(12'h495 + 12'(t), 8'h08 | 8'(1 << t));
    end
    rd(12'h49d, 8'hff);
    chk_full(1'b1);
    // Mid-run reset with flags up, first read right after release
    nrst_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1 nrst_i = 1'b1;
    rd(12'h49d, 8'h00);
    rd(12'h495, 8'h08);
    chk_full(1'b0);
    hit(5, 0, 255);
    rd(12'h495, 8'h09);
    chk_full(1'b1);
    // Soft reset must drop the saturated flag and count
    @(posedge clk_sys_i) #1 act = 8'h00;
    repeat (4) @(posedge clk_sys_i);
    #1 chk_full(1'b0);
    rd(12'h495, 8'h00);
    rd(12'h49d, 8'h00);
    repeat (2) @(posedge clk_sys_i);
    tally_and_finish();
  end
endmodule : lane_decode_error_monitor_test

/* tb/ldem_err_src.sv */
// Far-end error source: one decoded error pulse per request cycle
`timescale 1ns/1ns
module ldem_err_src (
  input logic clk_sys_i,
  input logic go_i,
  input logic [4:0] sel_i,
  output ldem_pkg::ldem_lane_err_t [7:0] err_o
);
  // Registered, so pulses leave just after the edge as from a real decoder
  always_ff @(posedge clk_sys_i) begin
    err_o <= go_i ? 24'h000001 << sel_i : 24'h000000;
  end
endmodule : ldem_err_src

/* tb/ldem_monitor_chk.sv */
// Port assertions for the lane decode error monitor
`timescale 1ns/1ns
module ldem_monitor_chk #(
  parameter int LANES = 8
) (
  input logic clk_sys_i,
  input logic nrst_i,
  input logic [LANES-1:0] lane_active_i,
  input ldem_pkg::ldem_lane_err_t [LANES-1:0] lane_err_i,
  input ldem_pkg::ldem_rd_req_t rd_req_i,
  input ldem_pkg::ldem_rd_rsp_t rd_rsp_o,
  input logic count_full_any_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  sequence s_stat_rd;
    rd_req_i.en && rd_req_i.addr inside {[12'h495:12'h497]};
  endsequence
  // Off sampled, then enable register, then flags, then summary register settle
  sequence s_all_off;
    lane_active_i == '0 ##1 1'b1 ##1 1'b1;
  endsequence
  a_read_latency: assert property (rd_req_i.en |=> rd_rsp_o.valid)
    else $error("read not answered");
  a_no_stray: assert property (!rd_req_i.en |=> !rd_rsp_o.valid)
    else $error("answer without read");
  a_data_holds: assert property (!rd_req_i.en |=> $stable(rd_rsp_o.data))
    else $error("read data moved");
  a_reserved_zero: assert property (s_stat_rd |=> rd_rsp_o.data[7:4] == 4'h0)
    else $error("reserved bits set");
  a_lane_active: assert property (rd_req_i.en && rd_req_i.addr == 12'h495 |=>
    rd_rsp_o.data[3] == $past(lane_active_i[5], 2)) else $error("enable bit wrong");
  a_unmapped_zero: assert property (rd_req_i.en && !(rd_req_i.addr inside {[12'h495:12'h49d]})
    |=> rd_rsp_o.data == 8'h00) else $error("unmapped read not zero");
  a_soft_clear: assert property (s_all_off |=> !count_full_any_o)
    else $error("flags survive soft reset");
  a_full_cause: assert property ($rose(count_full_any_o) |-> $past(lane_err_i, 2) != '0)
    else $error("full without error");
  a_hold_full: assert property ($fell(count_full_any_o) |-> $past(lane_active_i, 3) != '1)
    else $error("full dropped while active");
endmodule : ldem_monitor_chk
bind ldem_monitor ldem_monitor_chk #(.LANES(LANES)) ldem_monitor_chk_inst (.clk_sys_i(clk_sys_i),
  .nrst_i(nrst_i), .lane_active_i(lane_active_i), .lane_err_i(lane_err_i), .rd_req_i(rd_req_i),
  .rd_rsp_o(rd_rsp_o), .count_full_any_o(count_full_any_o));
